// >>> inc/bsr_defs.vh
`ifndef BSR_DEFS_VH
`define BSR_DEFS_VH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define BSR_OFF_CTRL   4'h0
`define BSR_OFF_STAGES 4'h4
`define BSR_OFF_STAT   4'h8
// ****************************************
// Control register fields
// ****************************************
`define BSR_CTRL_SEL_LO 0
`define BSR_CTRL_SEL_HI 2
`define BSR_CTRL_IDX_LO 4
`define BSR_CTRL_IDX_HI 5
`define BSR_CTRL_RET    8
`define BSR_CTRL_RST    32'h0000_0000
// ****************************************
// Bus answers
// ****************************************
`define BSR_RESP_OKAY   2'h0
`define BSR_RESP_SLVERR 2'h2
`endif

// >>> rtl/bsr_stage_mem.v
`timescale 1ns/10ps
// ****************************************
// Stage storage: one eight-bit word per register instance
// ****************************************
module bsr_stage_mem #(
  parameter NUM_REGS = 4,
  parameter IDX_W    = 2,
  parameter STAGES   = 8
) (
  // Clock
  input  wire              mclk_in,
  // Write port
  input  wire              wr_en_in,
  input  wire [IDX_W-1:0]  wr_idx_in,
  input  wire [STAGES-1:0] wr_data_in,
  // Read port, registered
  input  wire [IDX_W-1:0]  rd_idx_in,
  output reg  [STAGES-1:0] rd_data_out
);
  // Storage; no reset so contents survive a logic reset
  reg [STAGES-1:0] mem [0:NUM_REGS-1];

  // Write and registered read
  always @(posedge mclk_in) begin
    if (wr_en_in) begin
      mem[wr_idx_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_idx_in];
  end
endmodule

// >>> rtl/bsr_shift_reg.v
`timescale 1ns/10ps
`include "bsr_defs.vh"
// Functional notes
// - Trigger rising edge samples and shifts once
// - Trigger falling edge changes nothing
// - Direction 0: input enters stage 1
// - Direction 1: input enters stage 8
// - Output shows configured selected stage
// - Retentive: stages survive a logic reset
// - Non-retentive: stages cleared after restart
// - Index selects which register instance
// - Four independent instances, eight stages
module bsr_shift_reg #(
  parameter NUM_REGS = 4,
  parameter IDX_W    = 2,
  parameter STAGES   = 8
) (
  // Clock and reset
  input  wire        mclk_in,
  input  wire        rst_n_in,
  // Logic-side pins
  input  wire        shift_trg_in,
  input  wire        shift_dir_in,
  input  wire        serial_in,
  output reg         stage_bit_out,
  input  wire        stage_ready_in,
  output wire        stage_valid_out,
  output wire [7:0]  stage_word_out,
  // AXI4-Lite write address
  input  wire        s_axi_awvalid_in,
  output wire        s_axi_awready_out,
  input  wire [3:0]  s_axi_awaddr_in,
  // AXI4-Lite write data
  input  wire        s_axi_wvalid_in,
  output wire        s_axi_wready_out,
  input  wire [31:0] s_axi_wdata_in,
  input  wire [3:0]  s_axi_wstrb_in,
  // AXI4-Lite write response
  output reg         s_axi_bvalid_out,
  input  wire        s_axi_bready_in,
  output reg  [1:0]  s_axi_bresp_out,
  // AXI4-Lite read address
  input  wire        s_axi_arvalid_in,
  output wire        s_axi_arready_out,
  input  wire [3:0]  s_axi_araddr_in,
  // AXI4-Lite read data
  output reg         s_axi_rvalid_out,
  input  wire        s_axi_rready_in,
  output reg  [31:0] s_axi_rdata_out,
  output reg  [1:0]  s_axi_rresp_out
);
  // ****************************************
  // Control state
  // ****************************************
  reg  [31:0]       ctrl;          // Select, index, retentive
  reg               trg_prev;      // Trigger sample of last cycle
  reg               boot_done;     // Cleared at every reset
  reg               clr_busy;      // Clearing all instances
  reg  [IDX_W-1:0]  clr_idx;       // Instance being cleared
  reg               aw_held;       // Write address captured
  reg               w_held;        // Write data captured
  reg  [3:0]        aw_addr;       // Captured write address
  reg  [31:0]       w_data;        // Captured write data
  reg  [3:0]        w_strb;        // Captured strobes
  reg  [STAGES-1:0] shadow;        // Live copy of selected instance
  reg               pend;          // Pending shift from a trigger rising edge
  reg               pend_in;       // Input captured at pending edge
  reg               pend_dir;      // Direction captured at pending edge
  reg               loaded;        // Shadow matches memory read data
  reg  [IDX_W-1:0]  idx_q;         // Instance index of the last cycle
  reg               ret_keep;      // Retentive bit as it stood before reset

  wire [2:0]        sel   = ctrl[`BSR_CTRL_SEL_HI:`BSR_CTRL_SEL_LO];
  wire [IDX_W-1:0]  idx   = ctrl[`BSR_CTRL_IDX_HI:`BSR_CTRL_IDX_LO];
  wire              ret   = ctrl[`BSR_CTRL_RET];
  wire [STAGES-1:0] rd_word;

  // ****************************************
  // Trigger edge detection
  // ****************************************
  // Rising edge only; a falling edge leaves everything alone
  wire trg_rise = shift_trg_in & ~trg_prev;
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      trg_prev <= 1'b0;
    end else begin
      trg_prev <= shift_trg_in;
    end
  end

  // ****************************************
  // Output buffer back-pressure
  // ****************************************
  wire buf_in_ready;
  // A shift is only made when the two-entry buffer can take the new word,
  // so a stalled receiver loses nothing; the edge is held as pending.
  // No shift in the cycle in which an index change lands: the shadow still
  // holds the old instance there and would be written into the new one.
  wire do_shift = loaded & ~clr_busy & pend & buf_in_ready & (idx == idx_q);

  // Next stage word from the captured input and direction
  reg [STAGES-1:0] next_word;
  always @* begin
    if (pend_dir) begin
      next_word = {pend_in, shadow[STAGES-1:1]};
    end else begin
      next_word = {shadow[STAGES-2:0], pend_in};
    end
  end

  // ****************************************
  // Power-up clearing and stage update
  // ****************************************
  // Reset marks a restart; with the retentive bit clear all instances are cleared,
  // with it set they keep memory because the memory itself has no reset.
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      boot_done <= 1'b0;
      clr_busy  <= 1'b0;
      clr_idx   <= {IDX_W{1'b0}};
      pend      <= 1'b0;
      pend_in   <= 1'b0;
      pend_dir  <= 1'b0;
      loaded    <= 1'b0;
      shadow    <= {STAGES{1'b0}};
      idx_q     <= {IDX_W{1'b0}};
    end else begin
      idx_q    <= idx;
      ret_keep <= ret;
      if (!boot_done) begin
        boot_done <= 1'b1;
        // Reset clears the control word, so the choice uses the bit kept
        // from before reset; a cold flop of unknown value clears the stages
        if (ret_keep) begin
          clr_busy <= 1'b0;
        end else begin
          clr_busy <= 1'b1;
        end
      end else if (clr_busy) begin
        clr_idx <= clr_idx + 1'b1;
        if (clr_idx == NUM_REGS - 1) begin
          clr_busy <= 1'b0;
        end
      end
      // Catch a trigger edge; one shift at most per edge
      if (trg_rise && !pend) begin
        pend     <= 1'b1;
        pend_in  <= serial_in;
        pend_dir <= shift_dir_in;
      end else if (do_shift) begin
        pend <= 1'b0;
      end
      // Reload the shadow when the instance changes
      if (!boot_done || clr_busy || idx != idx_q) begin
        loaded <= 1'b0;
      end else if (!loaded) begin
        loaded <= 1'b1;
        shadow <= rd_word;
      end else if (do_shift) begin
        shadow <= next_word;
      end
    end
  end

  wire             mem_we   = clr_busy | do_shift;
  wire [IDX_W-1:0] mem_widx = clr_busy ? clr_idx : idx;
  wire [STAGES-1:0] mem_wd  = clr_busy ? {STAGES{1'b0}} : next_word;

  bsr_stage_mem #(
    .NUM_REGS (NUM_REGS),
    .IDX_W    (IDX_W),
    .STAGES   (STAGES)
  ) u_mem (
    .mclk_in     (mclk_in),
    .wr_en_in    (mem_we),
    .wr_idx_in   (mem_widx),
    .wr_data_in  (mem_wd),
    .rd_idx_in   (idx),
    .rd_data_out (rd_word)
  );

  // ****************************************
  // Selected stage output
  // ****************************************
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      stage_bit_out <= 1'b0;
    end else begin
      stage_bit_out <= shadow[sel];
    end
  end

  // ****************************************
  // Two-entry output buffer
  // ****************************************
  reg [7:0] buf0;
  reg [7:0] buf1;
  reg [1:0] buf_cnt;
  assign buf_in_ready    = (buf_cnt != 2'h2);
  assign stage_valid_out = (buf_cnt != 2'h0);
  assign stage_word_out  = buf0;
  wire buf_pop = stage_valid_out & stage_ready_in;
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      buf0    <= 8'h00;
      buf1    <= 8'h00;
      buf_cnt <= 2'h0;
    end else begin
      case ({do_shift, buf_pop})
        2'b10: begin
          if (buf_cnt == 2'h0) begin
            buf0 <= next_word;
          end else begin
            buf1 <= next_word;
          end
          buf_cnt <= buf_cnt + 2'h1;
        end
        2'b01: begin
          buf0    <= buf1;
          buf_cnt <= buf_cnt - 2'h1;
        end
        2'b11: begin
          if (buf_cnt == 2'h1) begin
            buf0 <= next_word;
          end else begin
            buf0 <= buf1;
            buf1 <= next_word;
          end
        end
        default: begin
          buf_cnt <= buf_cnt;
        end
      endcase
    end
  end

  // ****************************************
  // AXI4-Lite write path
  // ****************************************
  assign s_axi_awready_out = ~aw_held & ~s_axi_bvalid_out;
  assign s_axi_wready_out  = ~w_held & ~s_axi_bvalid_out;
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      aw_held          <= 1'b0;
      w_held           <= 1'b0;
      aw_addr          <= 4'h0;
      w_data           <= 32'h0000_0000;
      w_strb           <= 4'h0;
      ctrl             <= `BSR_CTRL_RST;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= `BSR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end
      if (aw_held && w_held) begin
        aw_held          <= 1'b0;
        w_held           <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        if (aw_addr == `BSR_OFF_CTRL) begin
          if (w_strb[0]) ctrl[7:0]  <= {2'h0, w_data[5:4], 1'b0, w_data[2:0]};
          if (w_strb[1]) ctrl[15:8] <= {7'h00, w_data[8]};
          s_axi_bresp_out <= `BSR_RESP_OKAY;
        end else if (aw_addr == `BSR_OFF_STAGES || aw_addr == `BSR_OFF_STAT) begin
          s_axi_bresp_out <= `BSR_RESP_OKAY;
        end else begin
          s_axi_bresp_out <= `BSR_RESP_SLVERR;
        end
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // ****************************************
  // AXI4-Lite read path
  // ****************************************
  assign s_axi_arready_out = ~s_axi_rvalid_out;
  always @(posedge mclk_in) begin
    if (!rst_n_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= 32'h0000_0000;
      s_axi_rresp_out  <= `BSR_RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out  <= `BSR_RESP_OKAY;
      case (s_axi_araddr_in)
        `BSR_OFF_CTRL:   s_axi_rdata_out <= ctrl;
        `BSR_OFF_STAGES: s_axi_rdata_out <= {24'h000000, shadow};
        `BSR_OFF_STAT:   s_axi_rdata_out <= {26'h0000000, buf_cnt, clr_busy,
                                             loaded, pend, stage_bit_out};
        default: begin
          s_axi_rdata_out <= 32'h0000_0000;
          s_axi_rresp_out <= `BSR_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end
endmodule

// >>> tb/bsr_shift_reg_assertions.sv
`timescale 1ns/10ps
// ****************
// Port checker
// ****************
module bsr_chk (
  input wire        mclk_in,
  input wire        rst_n_in,
  input wire        shift_trg_in,
  input wire        stage_ready_in,
  input wire        stage_valid_out,
  input wire [7:0]  stage_word_out,
  input wire        s_axi_bvalid_out,
  input wire        s_axi_bready_in,
  input wire        s_axi_arvalid_in,
  input wire        s_axi_arready_out,
  input wire [3:0]  s_axi_araddr_in,
  input wire        s_axi_rvalid_out,
  input wire        s_axi_rready_in,
  input wire [31:0] s_axi_rdata_out,
  input wire [1:0]  s_axi_rresp_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  a_b_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
    else $error("bvalid dropped");
  a_r_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read answer moved");
  a_ar_block: assert property (s_axi_arvalid_in && s_axi_arready_out |=>
    s_axi_rvalid_out && !s_axi_arready_out) else $error("read answer late or busy");
  a_rd_err: assert property (s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == 4'hC
    |=> s_axi_rvalid_out && s_axi_rresp_out == 2'h2 && s_axi_rdata_out == 32'h0)
    else $error("unmapped read answer");
  // A stalled word must not change or vanish
  a_word_hold: assert property (stage_valid_out && !stage_ready_in |=>
    stage_valid_out && $stable(stage_word_out)) else $error("word lost");
  a_rise_word: assert property (
    $rose(shift_trg_in) && !stage_valid_out |-> ##[1:12] stage_valid_out)
    else $error("no word after edge");
  a_fall_quiet: assert property (
    $fell(shift_trg_in) && !stage_valid_out |=> !stage_valid_out [*3])
    else $error("word after falling edge");
  // Reset is sampled, so the disable is switched off here
  a_rst_clear: assert property (disable iff (1'b0) !rst_n_in |=>
    !stage_valid_out && !s_axi_bvalid_out && !s_axi_rvalid_out) else $error("reset outputs");
endmodule

// >>> tb/bsr_partner.sv
`timescale 1ns/10ps
// ****************
// Far-side logic
// ****************
module bsr_partner (
  input  wire       mclk_in,
  input  wire       valid_in,
  input  wire [7:0] word_in,
  output reg        trg_out,
  output reg        dir_out,
  output reg        ser_out,
  output wire       ready_out
);
  logic       stall = 1'b0; // Bench holds words back with this
  logic [7:0] q[$];         // Words taken, in order
  initial begin
    trg_out = 1'b0;
    dir_out = 1'b0;
    ser_out = 1'b0;
  end
  assign ready_out = !stall;
  // Take a word at each handshake
  always @(posedge mclk_in) if (valid_in && ready_out) q.push_back(word_in);
  // One pulse, three cycles high; rising edges seven cycles apart, never closer than the block allows
  task shift(input logic d, input logic s);
    @(posedge mclk_in);
    dir_out <= d;
    ser_out <= s;
    trg_out <= 1'b1;
    repeat (3) @(posedge mclk_in);
    trg_out <= 1'b0;
    // Inputs flip on the falling edge, which must be ignored
    dir_out <= !d;
    ser_out <= !s;
    repeat (3) @(posedge mclk_in);
  endtask
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/10ps
`include "bsr_defs.vh"
module tb_top;
  logic        mclk_in, rst_n_in = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [3:0]  aw = 4'h0, ar = 4'h0;
  logic [31:0] wd = 32'h0, d;
  logic [1:0]  r;
  wire         trg, dir, ser, rdy, bit_o, val, awr, wrr, bv, arr, rv;
  wire  [7:0]  word;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  int          error_cnt = 0, checks = 0, cyc = 0, k;
  // {direction, serial bit, word after the shift}
  logic [9:0]  rows [6] = '{10'h101, 10'h103, 10'h006, 10'h383, 10'h241, 10'h183};
  bsr_shift_reg uut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .shift_trg_in(trg),
    .shift_dir_in(dir), .serial_in(ser), .stage_bit_out(bit_o), .stage_ready_in(rdy),
    .stage_valid_out(val), .stage_word_out(word), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_awaddr_in(aw), .s_axi_wvalid_in(wv),
    .s_axi_wready_out(wrr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(bre), .s_axi_bresp_out(bresp),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_araddr_in(ar),
    .s_axi_rvalid_out(rv), .s_axi_rready_in(rre), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp));
  bsr_partner p (.mclk_in(mclk_in), .valid_in(val), .word_in(word), .trg_out(trg),
    .dir_out(dir), .ser_out(ser), .ready_out(rdy));
  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = !mclk_in;
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    end
  endtask
  // Write: address and data offered together, each dropped when taken
  task wr(input logic [3:0] a, input logic [31:0] dt, output logic [1:0] rs);
    @(posedge mclk_in);
    aw <= a;
    wd <= dt;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge mclk_in);
      if (awr) awv <= 1'b0;
      if (wrr) wv <= 1'b0;
    end while (!bv);
    rs = bresp;
    bre <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [31:0] dt, output logic [1:0] rs);
    @(posedge mclk_in);
    ar <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge mclk_in);
      if (arr) arv <= 1'b0;
    end while (!rv);
    dt = rdata;
    rs = rresp;
    rre <= 1'b0;
  endtask
  task rst;
    @(posedge mclk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
  endtask
  // Poll status until the clear is over and the shadow is loaded
  task wait_ld;
    for (int n = 0; n < 20; n++) begin
      rd(`BSR_OFF_STAT, d, r);
      if (d[3:2] === 2'b01) break;
    end
  endtask
  task wq(input int n);
    for (int t = 0; t < 60 && p.q.size() < n; t++) @(posedge mclk_in);
  endtask
  initial begin
    rst();
    rd(`BSR_OFF_CTRL, d, r);
    chk("ctrl reset", d, `BSR_CTRL_RST);
    wait_ld();
    foreach (rows[i]) begin
      p.shift(rows[i][9], rows[i][8]);
      wq(i + 1);
      chk("word", p.q[i], rows[i][7:0]);
    end
    chk("words", p.q.size(), 6);
    rd(`BSR_OFF_STAGES, d, r);
    chk("stages", d, 32'h83);
    for (k = 0; k < 8; k++) begin
      wr(`BSR_OFF_CTRL, k, r);
      repeat (3) @(posedge mclk_in);
      chk("out", bit_o, 32'h83 >> k & 1);
    end
    $display("test table done");
    p.stall <= 1'b1;
    repeat (3) p.shift(1'b0, 1'b0);
    p.stall <= 1'b0;
    wq(9);
    chk("stalled", p.q[8], 8'h18);
    wr(`BSR_OFF_CTRL, 32'h10, r);
    wait_ld();
    rd(`BSR_OFF_STAGES, d, r);
    chk("index 2", d, 0);
    p.shift(1'b0, 1'b1);
    wq(10);
    rd(`BSR_OFF_STAGES, d, r);
    chk("index 2 shift", d, 1);
    wr(`BSR_OFF_CTRL, 0, r);
    wait_ld();
    rd(`BSR_OFF_STAGES, d, r);
    chk("index 1 kept", d, 32'h18);
    rd(4'hC, d, r);
    chk("bad rresp", r, `BSR_RESP_SLVERR);
    chk("bad rdata", d, 0);
    wr(4'hC, 1, r);
    chk("bad bresp", r, `BSR_RESP_SLVERR);
    wr(`BSR_OFF_STAGES, 32'hFF, r);
    chk("ro bresp", r, `BSR_RESP_OKAY);
    $display("test bus done");
    wr(`BSR_OFF_CTRL, 32'h100, r);
    // A slow master: the read answer must stand until rready comes
    @(posedge mclk_in);
    ar  <= `BSR_OFF_CTRL;
    arv <= 1'b1;
    @(posedge mclk_in);
    arv <= 1'b0;
    repeat (4) @(posedge mclk_in);
    chk("late rvalid", rv, 1);
    rre <= 1'b1;
    @(posedge mclk_in);
    chk("late rdata", rdata, 32'h100);
    rre <= 1'b0;
    rst();
    wait_ld();
    rd(`BSR_OFF_STAGES, d, r);
    chk("retained", d, 32'h18);
    rst();
    wait_ld();
    rd(`BSR_OFF_STAGES, d, r);
    chk("cleared", d, 0);
    $display("test power done");
    report_and_stop();
  end
endmodule
bind bsr_shift_reg bsr_chk chk_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
  .shift_trg_in(shift_trg_in), .stage_ready_in(stage_ready_in),
  .stage_valid_out(stage_valid_out), .stage_word_out(stage_word_out),
  .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
  .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
  .s_axi_araddr_in(s_axi_araddr_in), .s_axi_rvalid_out(s_axi_rvalid_out),
  .s_axi_rready_in(s_axi_rready_in), .s_axi_rdata_out(s_axi_rdata_out),
  .s_axi_rresp_out(s_axi_rresp_out));
